// file: plca_fabric.sv
// Logic control, pin I/O, input and shared control cells of the fabric
`timescale 1ns/1ps
`include "plca_defs.svh"

// Behaviour
// R1: Sum A is D, T, J or combinatorial
// R2: Sum B is K, preset or combinatorial
// R3: Sum C is clock, reset or combinatorial
// R4: Sum D is clock or pin output enable
// R5: Controls come from full sum terms
// R6: Each output picks Q or sum A/B/C
// R7: Shared system clock, selectable edge polarity
// R8: Shared preset and reset to governed registers
// R9: Shared register-type signal switches flip-flop type
// R10: Pin cell attaches to any control cell
// R11: Pin cell: register/latch, three-state, inversion
// R12: Input storage clocked by shared source, bypassable
// R13: Dedicated output: input register clocked by D
// R14: Twelve input-only cells, mux plus storage
// R15: Second group governs upper half of cells
// R16: Without second group, first governs all
// R17: Input cells clocked by first group by default
// R18: Third group picks clock pin or term
// R19: 24 control, 24 pin, 12 input cells
// R20: One output to pin, other buried
// R21: Register D/T/JK, synchronous or asynchronous
// R22: Reset beats preset when both active
// R23: T toggles; JK holds, clears, sets, toggles
module plca_fabric #(
  parameter int N_LGC = `PLCA_N_LGC,
  parameter int N_INC = `PLCA_N_INC
) (
  input  wire logic                                   clk_in,
  input  wire logic                                   sys_rst_in,
  input  wire logic [`PLCA_N_SYSCLK-1:0]              sys_clk_pin_in,
  input  wire logic [N_INC-1:0]                       inc_pin_in,
  input  wire logic [N_LGC-1:0]                       io_pin_in,
  input  wire plca_pkg::plca_sums_s    [N_LGC-1:0]    sums_in,
  input  wire plca_pkg::plca_lgc_cfg_s [N_LGC-1:0]    lgc_cfg_in,
  input  wire plca_pkg::plca_pio_cfg_s [N_LGC-1:0]    pio_cfg_in,
  input  wire plca_pkg::plca_store_e   [N_INC-1:0]    inc_store_in,
  input  wire plca_pkg::plca_glb_s     [1:0]          glb_in,
  input  wire logic                                   grp_b_en_in,
  input  wire logic                                   glb_c_en_in,
  input  wire plca_pkg::plca_gcsrc_e                  glb_c_src_in,
  input  wire logic                                   glb_c_pterm_in,
  output logic [N_LGC-1:0]                            io_pin_out,
  output logic [N_LGC-1:0]                            io_pin_oe_out,
  output logic [N_LGC-1:0]                            io_array_out,
  output logic [N_INC-1:0]                            inc_array_out,
  output logic [N_LGC-1:0]                            lgc_buried_out
);

  localparam int NCK = `PLCA_N_SYSCLK;
  localparam int W   = NCK + N_INC + N_LGC;
  localparam int INB = NCK;
  localparam int IOB = NCK + N_INC;

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Two equal halves are needed for the group split
  if (N_LGC < 2 || (N_LGC % 2) != 0 || N_LGC > (1 << `PLCA_SEL_W)) begin : g_bad_lgc
    $error("N_LGC must be even, at least 2, and fit the select field"); // [R19]
  end
  if (N_INC < 1) begin : g_bad_inc
    $error("N_INC must be at least 1"); // [R14]
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic grp_of(input int idx, input logic b_en);
    return b_en && (idx >= N_LGC / 2); // [R15] [R16]
  endfunction : grp_of

  function automatic logic out_pick(input plca_pkg::plca_osel_e s,
                                    input logic q,
                                    input plca_pkg::plca_sums_s t);
    case (s)
      plca_pkg::PLCA_O_A: return t.a;
      plca_pkg::PLCA_O_B: return t.b;
      plca_pkg::PLCA_O_C: return t.c;
      default: return q;
    endcase
  endfunction : out_pick

  function automatic logic stored(input plca_pkg::plca_store_e m,
                                  input logic tick,
                                  input logic lvl,
                                  input logic data,
                                  input logic cur);
    case (m)
      plca_pkg::PLCA_ST_REG: return tick ? data : cur;
      plca_pkg::PLCA_ST_LATCH: return lvl ? data : cur;
      default: return data;
    endcase
  endfunction : stored

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; a level counts only once stages two and three agree
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] pin_st;
  logic [W-1:0] next_pin_st;

  always_comb begin
    next_pin_st = (s2 & s3) | (pin_st & (s2 ^ s3));
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      pin_st <= '0;
    end else begin
      s1     <= {io_pin_in, inc_pin_in, sys_clk_pin_in};
      s2     <= s1;
      s3     <= s2;
      pin_st <= next_pin_st;
    end
  end

  // ****************************************
  // Edge history
  // ****************************************
  // Sum-term clocks act on their rising edge, seen in the same cycle against last cycle's value
  logic [NCK-1:0]   ck_prev;
  logic [N_LGC-1:0] c_prev;
  logic [N_LGC-1:0] d_prev;
  logic             pt_prev;
  logic [N_LGC-1:0] next_c_prev;
  logic [N_LGC-1:0] next_d_prev;

  always_comb begin
    for (int i = 0; i < N_LGC; i++) begin
      next_c_prev[i] = sums_in[i].c;
      next_d_prev[i] = sums_in[i].d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ck_prev <= '0;
      c_prev  <= '0;
      d_prev  <= '0;
      pt_prev <= 1'b0;
    end else begin
      ck_prev <= pin_st[NCK-1:0];
      c_prev  <= next_c_prev;
      d_prev  <= next_d_prev;
      pt_prev <= glb_c_pterm_in;
    end
  end

  // ****************************************
  // Shared control cells
  // ****************************************
  logic [NCK-1:0]   ck_rise;
  logic [NCK-1:0]   ck_fall;
  logic [1:0]       grp_tick;
  logic [1:0]       grp_lvl;
  logic             inc_tick;
  logic             inc_lvl;
  logic [N_LGC-1:0] lgc_grp;

  always_comb begin
    ck_rise = pin_st[NCK-1:0] & ~ck_prev;
    ck_fall = ~pin_st[NCK-1:0] & ck_prev;
    for (int g = 0; g < 2; g++) begin
      grp_lvl[g]  = pin_st[glb_in[g].clk_sel] ^ glb_in[g].clk_pol; // [R7]
      grp_tick[g] = glb_in[g].clk_pol ? ck_fall[glb_in[g].clk_sel]
                                      : ck_rise[glb_in[g].clk_sel]; // [R7]
    end
    for (int i = 0; i < N_LGC; i++) begin
      lgc_grp[i] = grp_of(i, grp_b_en_in); // [R15] [R16]
    end
    // Input cells follow group A unless group C is chosen
    inc_tick = grp_tick[0]; // [R17]
    inc_lvl  = grp_lvl[0];
    if (glb_c_en_in) begin
      case (glb_c_src_in) // [R18]
        plca_pkg::PLCA_GC_SYS2: begin
          inc_tick = ck_rise[1];
          inc_lvl  = pin_st[1];
        end
        plca_pkg::PLCA_GC_PTERM: begin
          inc_tick = glb_c_pterm_in & ~pt_prev;
          inc_lvl  = glb_c_pterm_in;
        end
        default: begin
          inc_tick = ck_rise[0];
          inc_lvl  = pin_st[0];
        end
      endcase
    end
  end

  // ****************************************
  // Logic control cells
  // ****************************************
  logic                lgc_tick [N_LGC];
  logic                lgc_k    [N_LGC];
  logic                lgc_pre  [N_LGC];
  logic                lgc_rst  [N_LGC];
  plca_pkg::plca_reg_e lgc_type [N_LGC];
  logic [N_LGC-1:0]    lgc_q;
  logic [N_LGC-1:0]    lgc_pin;
  logic [N_LGC-1:0]    lgc_bur;

  always_comb begin
    for (int i = 0; i < N_LGC; i++) begin
      // Type may flip at run time for loadable counters
      lgc_type[i] = glb_in[lgc_grp[i]].regtype ? lgc_cfg_in[i].alt_type
                                               : lgc_cfg_in[i].reg_type; // [R9]
      case (lgc_cfg_in[i].clk_src)
        plca_pkg::PLCA_CK_SUMC: lgc_tick[i] = sums_in[i].c & ~c_prev[i]; // [R3] [R5]
        plca_pkg::PLCA_CK_SUMD: lgc_tick[i] = sums_in[i].d & ~d_prev[i]; // [R4] [R5]
        default: lgc_tick[i] = grp_tick[lgc_grp[i]]; // [R7]
      endcase
      lgc_k[i]   = sums_in[i].b & ~lgc_cfg_in[i].b_is_preset; // [R2]
      lgc_pre[i] = (lgc_cfg_in[i].b_is_preset & sums_in[i].b)
                   | glb_in[lgc_grp[i]].preset; // [R2] [R5] [R8]
      lgc_rst[i] = (lgc_cfg_in[i].c_is_reset & sums_in[i].c)
                   | glb_in[lgc_grp[i]].reset; // [R3] [R5] [R8]
      lgc_pin[i] = out_pick(lgc_cfg_in[i].pin_sel, lgc_q[i], sums_in[i]); // [R6] [R20]
      lgc_bur[i] = out_pick(lgc_cfg_in[i].bur_sel, lgc_q[i], sums_in[i]); // [R6] [R20]
    end
  end

  for (genvar i = 0; i < N_LGC; i++) begin : g_lgc
    plca_cell_reg u_reg (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .tick_in    (lgc_tick[i]),
      .dtj_in     (sums_in[i].a),
      .k_in       (lgc_k[i]),
      .type_in    (lgc_type[i]),
      .preset_in  (lgc_pre[i]),
      .reset_in   (lgc_rst[i]),
      .sync_in    (lgc_cfg_in[i].sync_mode),
      .q_out      (lgc_q[i])
    );

    a_buried_pick: assert property ( // [R6]
      @(posedge clk_in) disable iff (sys_rst_in)
      (lgc_cfg_in[i].bur_sel == plca_pkg::PLCA_O_A)
      |=> lgc_buried_out[i] == $past(sums_in[i].a))
      else $error("buried output did not follow sum A");
  end

  // ****************************************
  // Pin and input cells
  // ****************************************
  logic [N_LGC-1:0] next_io_out;
  logic [N_LGC-1:0] next_io_oe;
  logic [N_LGC-1:0] next_io_arr;
  logic [N_INC-1:0] next_inc_arr;

  always_comb begin
    int  src;
    logic tick;
    logic lvl;
    logic data;
    src  = 0;
    tick = 1'b0;
    lvl  = 1'b0;
    data = 1'b0;
    for (int j = 0; j < N_LGC; j++) begin
      // Out-of-range select falls back to cell zero
      src = (int'(pio_cfg_in[j].lgc_sel) < N_LGC) ? int'(pio_cfg_in[j].lgc_sel) : 0; // [R10]
      next_io_out[j] = lgc_pin[src] ^ pio_cfg_in[j].invert; // [R11]
      next_io_oe[j]  = lgc_cfg_in[src].d_is_oe ? sums_in[src].d
                                               : pio_cfg_in[j].oe_static; // [R4] [R11]
      if (pio_cfg_in[j].dedicated) begin
        tick = sums_in[src].d & ~d_prev[src]; // [R13]
        lvl  = sums_in[src].d;
        data = lgc_pin[src];
      end else begin
        tick = grp_tick[lgc_grp[j]]; // [R12]
        lvl  = grp_lvl[lgc_grp[j]];
        data = pin_st[IOB + j];
      end
      next_io_arr[j] = stored(pio_cfg_in[j].store, tick, lvl, data, io_array_out[j]); // [R11] [R12]
    end
    for (int k = 0; k < N_INC; k++) begin
      next_inc_arr[k] = stored(inc_store_in[k], inc_tick, inc_lvl,
                               pin_st[INB + k], inc_array_out[k]); // [R12] [R14]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      io_pin_out     <= '0;
      io_pin_oe_out  <= '0;
      io_array_out   <= '0;
      inc_array_out  <= '0;
      lgc_buried_out <= '0;
    end else begin
      io_pin_out     <= next_io_out;
      io_pin_oe_out  <= next_io_oe;
      io_array_out   <= next_io_arr;
      inc_array_out  <= next_inc_arr;
      lgc_buried_out <= lgc_bur; // [R20]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_single_group: assert property ( // [R16]
    @(posedge clk_in) disable iff (sys_rst_in)
    !grp_b_en_in |-> lgc_grp == '0)
    else $error("group B active while disabled");

  a_upper_group: assert property ( // [R15]
    @(posedge clk_in) disable iff (sys_rst_in)
    grp_b_en_in |-> (lgc_grp[N_LGC-1] && !lgc_grp[0]))
    else $error("group split wrong");

  a_oe_sum: assert property ( // [R4]
    @(posedge clk_in) disable iff (sys_rst_in)
    (int'(pio_cfg_in[0].lgc_sel) < N_LGC && lgc_cfg_in[pio_cfg_in[0].lgc_sel].d_is_oe)
    |=> io_pin_oe_out[0] == $past(sums_in[pio_cfg_in[0].lgc_sel].d))
    else $error("output enable did not follow sum D");

  a_inc_bypass: assert property ( // [R12]
    @(posedge clk_in) disable iff (sys_rst_in)
    (inc_store_in[0] == plca_pkg::PLCA_ST_BYPASS)
    |=> inc_array_out[0] == $past(pin_st[INB]))
    else $error("bypassed input cell did not follow pin");

endmodule : plca_fabric

// file: plca_defs.svh
// Counts, field widths and reset values of the logic cell fabric
`ifndef PLCA_DEFS_SVH
`define PLCA_DEFS_SVH

// ****************************************
// Fabric sizes
// ****************************************
`define PLCA_N_LGC 24
`define PLCA_N_INC 12
`define PLCA_N_SYSCLK 2
`define PLCA_SEL_W 5

// ****************************************
// Reset values
// ****************************************
`define PLCA_Q_RST 1'b0
`define PLCA_OUT_RST 1'b0

`endif

// file: plca_pkg.sv
// Types shared by the logic cell fabric files
package plca_pkg;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {PLCA_REG_D, PLCA_REG_T, PLCA_REG_JK} plca_reg_e;
  typedef enum logic [1:0] {PLCA_CK_SYS, PLCA_CK_SUMC, PLCA_CK_SUMD} plca_clk_e;
  typedef enum logic [1:0] {PLCA_O_Q, PLCA_O_A, PLCA_O_B, PLCA_O_C} plca_osel_e;
  typedef enum logic [1:0] {PLCA_ST_BYPASS, PLCA_ST_REG, PLCA_ST_LATCH} plca_store_e;
  typedef enum logic [1:0] {PLCA_GC_SYS1, PLCA_GC_SYS2, PLCA_GC_PTERM} plca_gcsrc_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } plca_sums_s;

  typedef struct packed {
    plca_reg_e  reg_type;
    plca_reg_e  alt_type;
    plca_clk_e  clk_src;
    logic       b_is_preset;
    logic       c_is_reset;
    logic       d_is_oe;
    logic       sync_mode;
    plca_osel_e pin_sel;
    plca_osel_e bur_sel;
  } plca_lgc_cfg_s;

  typedef struct packed {
    logic [4:0]  lgc_sel;
    plca_store_e store;
    logic        invert;
    logic        oe_static;
    logic        dedicated;
  } plca_pio_cfg_s;

  typedef struct packed {
    logic clk_sel;
    logic clk_pol;
    logic preset;
    logic reset;
    logic regtype;
  } plca_glb_s;

endpackage : plca_pkg

// file: plca_cell_reg.sv
// Configurable D, T or JK register of one logic control cell
`timescale 1ns/1ps
`include "plca_defs.svh"

module plca_cell_reg (
  input  wire logic                clk_in,
  input  wire logic                sys_rst_in,
  input  wire logic                tick_in,
  input  wire logic                dtj_in,
  input  wire logic                k_in,
  input  wire plca_pkg::plca_reg_e type_in,
  input  wire logic                preset_in,
  input  wire logic                reset_in,
  input  wire logic                sync_in,
  output logic                     q_out
);

  logic next_q;
  logic ctl_ok;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_q = q_out;
    if (tick_in) begin
      case (type_in)
        plca_pkg::PLCA_REG_D: next_q = dtj_in; // [R1] [R21]
        plca_pkg::PLCA_REG_T: next_q = dtj_in ? ~q_out : q_out; // [R23]
        plca_pkg::PLCA_REG_JK: begin
          case ({dtj_in, k_in}) // [R23]
            2'b01: next_q = 1'b0;
            2'b10: next_q = 1'b1;
            2'b11: next_q = ~q_out;
            default: next_q = q_out;
          endcase
        end
        default: next_q = q_out;
      endcase
    end
    // Sync mode waits for the cell clock; reset beats preset
    ctl_ok = ~sync_in | tick_in; // [R21]
    if (ctl_ok && reset_in) begin
      next_q = 1'b0; // [R22]
    end else if (ctl_ok && preset_in) begin
      next_q = 1'b1; // [R2] [R8]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q_out <= `PLCA_Q_RST;
    end else begin
      q_out <= next_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reset_wins: assert property ( // [R22]
    @(posedge clk_in) disable iff (sys_rst_in)
    (reset_in && preset_in && !sync_in) |=> !q_out)
    else $error("reset did not beat preset");

  a_async_preset: assert property ( // [R21]
    @(posedge clk_in) disable iff (sys_rst_in)
    (preset_in && !reset_in && !sync_in) |=> q_out)
    else $error("async preset not applied");

  a_sync_holds: assert property ( // [R21]
    @(posedge clk_in) disable iff (sys_rst_in)
    (sync_in && !tick_in) |=> $stable(q_out))
    else $error("sync register moved without clock");

  a_t_toggle: assert property ( // [R23]
    @(posedge clk_in) disable iff (sys_rst_in)
    (tick_in && type_in == plca_pkg::PLCA_REG_T && dtj_in && !preset_in && !reset_in)
    |=> q_out != $past(q_out))
    else $error("T register failed to toggle");

  a_jk_hold: assert property ( // [R23]
    @(posedge clk_in) disable iff (sys_rst_in)
    (tick_in && type_in == plca_pkg::PLCA_REG_JK && !dtj_in && !k_in
     && !preset_in && !reset_in) |=> $stable(q_out))
    else $error("JK register did not hold");

  a_d_load: assert property ( // [R1]
    @(posedge clk_in) disable iff (sys_rst_in)
    (tick_in && type_in == plca_pkg::PLCA_REG_D && !preset_in && !reset_in)
    |=> q_out == $past(dtj_in))
    else $error("D register did not load");

endmodule : plca_cell_reg

// file: plca_board.sv
// Board logic model driving the system clock, input and pin lines of the fabric
`timescale 1ns/1ps
`include "plca_defs.svh"

module plca_board (
  input  wire logic [0:0]                 clk_in,
  input  wire logic [`PLCA_N_SYSCLK-1:0]  sys_lvl_in,
  input  wire logic [`PLCA_N_INC-1:0]     inc_lvl_in,
  input  wire logic [`PLCA_N_LGC-1:0]     io_lvl_in,
  input  wire logic [`PLCA_N_LGC-1:0]     dev_pin_in,
  input  wire logic [`PLCA_N_LGC-1:0]     dev_oe_in,
  output logic      [`PLCA_N_SYSCLK-1:0]  sys_clk_pin_out,
  output logic      [`PLCA_N_INC-1:0]     inc_pin_out,
  output logic      [`PLCA_N_LGC-1:0]     io_wire_out
);
  // ********************
  // Board drivers
  // ********************
  logic [`PLCA_N_LGC-1:0] board_drv;

  initial begin
    sys_clk_pin_out = '0;
    inc_pin_out     = '0;
    board_drv       = '0;
  end

  // Lines move just after the edge, clock pins stand still unless commanded
  always @(posedge clk_in) begin
    sys_clk_pin_out <= sys_lvl_in;
    inc_pin_out     <= inc_lvl_in;
    board_drv       <= io_lvl_in;
  end

  // Board backs off wherever the fabric enables its driver
  assign io_wire_out = (dev_oe_in & dev_pin_in) | (~dev_oe_in & board_drv);
endmodule : plca_board

// file: tb.sv
// Self-checking testbench of the logic cell fabric
`timescale 1ns/1ps
`include "plca_defs.svh"

module tb;
  // ********************
  // Signals
  // ********************
  localparam logic [9:0] JK_SEQ = 10'h12F;  // J/K pairs 01,00,10,11,11
  localparam logic [4:0] JK_Q   = 5'h05;    // State after each tick, from one
  logic                                  clk_in;
  logic                                  sys_rst_in;
  logic [`PLCA_N_SYSCLK-1:0]             sys_clk_pin, sys_lvl;
  logic [`PLCA_N_INC-1:0]                inc_pin, inc_lvl, inc_array_out;
  logic [`PLCA_N_LGC-1:0]                io_pin, io_lvl, io_pin_out, io_pin_oe_out, io_array_out, lgc_buried_out;
  plca_pkg::plca_sums_s    [`PLCA_N_LGC-1:0] sums;
  plca_pkg::plca_lgc_cfg_s [`PLCA_N_LGC-1:0] lgc;
  plca_pkg::plca_pio_cfg_s [`PLCA_N_LGC-1:0] pio;
  plca_pkg::plca_store_e   [`PLCA_N_INC-1:0] inc_store;
  plca_pkg::plca_glb_s     [1:0]             glb;
  logic                                  grp_b_en, glb_c_en, pterm;
  plca_pkg::plca_gcsrc_e                 glb_c_src;
  int                                    err_total, comparisons;

  plca_fabric #(.N_LGC(`PLCA_N_LGC), .N_INC(`PLCA_N_INC)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sys_clk_pin_in(sys_clk_pin), .inc_pin_in(inc_pin),
    .io_pin_in(io_pin), .sums_in(sums), .lgc_cfg_in(lgc), .pio_cfg_in(pio), .inc_store_in(inc_store),
    .glb_in(glb), .grp_b_en_in(grp_b_en), .glb_c_en_in(glb_c_en), .glb_c_src_in(glb_c_src),
    .glb_c_pterm_in(pterm), .io_pin_out(io_pin_out), .io_pin_oe_out(io_pin_oe_out),
    .io_array_out(io_array_out), .inc_array_out(inc_array_out), .lgc_buried_out(lgc_buried_out));

  plca_board u_board (
    .clk_in(clk_in), .sys_lvl_in(sys_lvl), .inc_lvl_in(inc_lvl), .io_lvl_in(io_lvl),
    .dev_pin_in(io_pin_out), .dev_oe_in(io_pin_oe_out), .sys_clk_pin_out(sys_clk_pin),
    .inc_pin_out(inc_pin), .io_wire_out(io_pin));

  // ********************
  // Tasks
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  // Pins need several cycles to pass the synchronisers, so every step settles long
  task automatic set(input int f, input logic v);
    @(posedge clk_in);
    case (f)
      0: sums[0].a <= v;
      1: sums[0].b <= v;
      2: sums[0].c <= v;
      3: sums[0].d <= v;
      4: sys_lvl[0] <= v;
      5: sys_lvl[1] <= v;
      6: pterm <= v;
      7: io_lvl[3] <= v;
      8: inc_lvl[0] <= v;
      9: glb[0].regtype <= v;
      10: glb[0].preset <= v;
      11: glb[0].reset <= v;
      12: glb[1].reset <= v;
      default: grp_b_en <= v;
    endcase
    cyc(10);
  endtask : set

  task automatic pulse(input int f);
    set(f, 1'b1);
    set(f, 1'b0);
  endtask : pulse

  task automatic chk(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, g, e);
    end
  endtask : chk

  task automatic chkv(input logic [`PLCA_N_LGC-1:0] g, input logic [`PLCA_N_LGC-1:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t vector got %h exp %h", $time, g, e);
    end
  endtask : chkv

  task automatic conclude();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // ********************
  // Stimulus
  // ********************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    conclude();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    sys_rst_in = 1'b1;
    {sys_lvl, inc_lvl, io_lvl, grp_b_en, glb_c_en, pterm} = '0;
    sums = '0;
    glb = '0;
    inc_store = '0;
    glb_c_src = plca_pkg::PLCA_GC_SYS1;
    for (int i = 0; i < `PLCA_N_LGC; i++) begin
      lgc[i] = '0;
      lgc[i].clk_src = plca_pkg::PLCA_CK_SUMC;
      pio[i] = '0;
      pio[i].lgc_sel = 5'(i);
    end
    repeat (11) @(posedge clk_in);
    #1;
    chkv(lgc_buried_out | io_pin_oe_out | io_pin_out, 24'h000000);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cyc(2);
    for (int s = 1; s < 4; s++) begin
      @(posedge clk_in);
      lgc[0].pin_sel <= plca_pkg::plca_osel_e'(s);
      sums[0] <= plca_pkg::plca_sums_s'(4'h8 >> (s - 1));
      cyc(4);
      chk(io_pin_out[0], 1'b1);
      chk(lgc_buried_out[0], 1'b0);
    end
    @(posedge clk_in);
    sums[0] <= '0;
    lgc[0].pin_sel <= plca_pkg::PLCA_O_Q;
    set(0, 1'b1);
    pulse(2);
    chk(lgc_buried_out[0], 1'b1);
    set(0, 1'b0);
    pulse(2);
    chk(lgc_buried_out[0], 1'b0);
    @(posedge clk_in);
    lgc[0].clk_src <= plca_pkg::PLCA_CK_SUMD;
    set(0, 1'b1);
    pulse(2);
    chk(lgc_buried_out[0], 1'b0);
    pulse(3);
    chk(lgc_buried_out[0], 1'b1);
    @(posedge clk_in);
    lgc[0].clk_src <= plca_pkg::PLCA_CK_SUMC;
    lgc[0].reg_type <= plca_pkg::PLCA_REG_T;
    pulse(2);
    chk(lgc_buried_out[0], 1'b0);
    pulse(2);
    chk(lgc_buried_out[0], 1'b1);
    set(0, 1'b0);
    pulse(2);
    chk(lgc_buried_out[0], 1'b1);
    @(posedge clk_in);
    lgc[0].reg_type <= plca_pkg::PLCA_REG_JK;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      {sums[0].a, sums[0].b} <= JK_SEQ[9 - 2 * i -: 2];
      cyc(2);
      pulse(2);
      chk(lgc_buried_out[0], JK_Q[4 - i]);
    end
    @(posedge clk_in);
    lgc[0].reg_type <= plca_pkg::PLCA_REG_D;
    lgc[0].alt_type <= plca_pkg::PLCA_REG_T;
    set(9, 1'b1);
    pulse(2);
    chk(lgc_buried_out[0], 1'b0);
    pulse(2);
    chk(lgc_buried_out[0], 1'b1);
    set(9, 1'b0);
    pulse(2);
    chk(lgc_buried_out[0], 1'b1);
    @(posedge clk_in);
    lgc[0].b_is_preset <= 1'b1;
    lgc[0].c_is_reset <= 1'b1;
    lgc[0].clk_src <= plca_pkg::PLCA_CK_SUMD;
    sums[0].b <= 1'b0;
    set(2, 1'b1);
    chk(lgc_buried_out[0], 1'b0);
    set(1, 1'b1);
    chk(lgc_buried_out[0], 1'b0);
    set(2, 1'b0);
    chk(lgc_buried_out[0], 1'b1);
    set(1, 1'b0);
    @(posedge clk_in);
    lgc[0].b_is_preset <= 1'b0;
    lgc[0].c_is_reset <= 1'b0;
    set(10, 1'b1);
    chkv(lgc_buried_out, 24'hFFFFFF);
    set(13, 1'b1);
    set(12, 1'b1);
    chkv(lgc_buried_out, 24'h000FFF);
    set(11, 1'b1);
    chkv(lgc_buried_out, 24'h000000);
    set(13, 1'b0);
    set(11, 1'b0);
    chkv(lgc_buried_out, 24'hFFFFFF);
    set(10, 1'b0);
    set(12, 1'b0);
    // Edge polarity: falling only while the polarity bit is set
    @(posedge clk_in);
    lgc[0].clk_src <= plca_pkg::PLCA_CK_SYS;
    glb[0].clk_pol <= 1'b1;
    set(0, 1'b0);
    set(4, 1'b1);
    chk(lgc_buried_out[0], 1'b1);
    set(4, 1'b0);
    chk(lgc_buried_out[0], 1'b0);
    @(posedge clk_in);
    glb[0].clk_pol <= 1'b0;
    set(0, 1'b1);
    set(4, 1'b1);
    chk(lgc_buried_out[0], 1'b1);
    set(4, 1'b0);
    @(posedge clk_in);
    pio[5].lgc_sel <= 5'h00;
    pio[5].invert <= 1'b1;
    lgc[0].pin_sel <= plca_pkg::PLCA_O_A;
    lgc[0].d_is_oe <= 1'b1;
    cyc(6);
    chk(io_pin_out[5], 1'b0);
    chk(io_pin_out[0], 1'b1);
    set(3, 1'b1);
    chk(io_pin_oe_out[5], 1'b1);
    set(3, 1'b0);
    chk(io_pin_oe_out[5], 1'b0);
    @(posedge clk_in);
    lgc[0].d_is_oe <= 1'b0;
    pio[5].oe_static <= 1'b1;
    pio[3].store <= plca_pkg::PLCA_ST_LATCH;
    cyc(6);
    chk(io_pin_oe_out[5], 1'b1);
    set(7, 1'b1);
    chk(io_array_out[3], 1'b0);
    set(4, 1'b1);
    chk(io_array_out[3], 1'b1);
    set(7, 1'b0);
    chk(io_array_out[3], 1'b0);
    set(4, 1'b0);
    set(7, 1'b1);
    chk(io_array_out[3], 1'b0);
    @(posedge clk_in);
    pio[3].store <= plca_pkg::PLCA_ST_REG;
    set(4, 1'b1);
    chk(io_array_out[3], 1'b1);
    set(7, 1'b0);
    set(4, 1'b0);
    chk(io_array_out[3], 1'b1);
    set(4, 1'b1);
    chk(io_array_out[3], 1'b0);
    @(posedge clk_in);
    pio[3].store <= plca_pkg::PLCA_ST_BYPASS;
    set(7, 1'b1);
    chk(io_array_out[3], 1'b1);
    set(4, 1'b0);
    // Input cell clocks: first group by default, then each source of the third group
    @(posedge clk_in);
    inc_store[0] <= plca_pkg::PLCA_ST_REG;
    set(8, 1'b1);
    pulse(5);
    chk(inc_array_out[0], 1'b0);
    pulse(4);
    chk(inc_array_out[0], 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      glb_c_en <= 1'b1;
      glb_c_src <= plca_pkg::plca_gcsrc_e'(i);
      set(8, i[0]);
      pulse(4 + i);
      chk(inc_array_out[0], i[0]);
    end
    @(posedge clk_in);
    inc_store[0] <= plca_pkg::PLCA_ST_BYPASS;
    set(8, 1'b1);
    chk(inc_array_out[0], 1'b1);
    @(posedge clk_in);
    pio[0].dedicated <= 1'b1;
    pio[0].store <= plca_pkg::PLCA_ST_REG;
    set(0, 1'b0);
    pulse(3);
    chk(io_array_out[0], 1'b0);
    set(0, 1'b1);
    chk(io_array_out[0], 1'b0);
    pulse(3);
    chk(io_array_out[0], 1'b1);
    conclude();
  end
endmodule : tb
